/* File: rtl/pci_consts.vh */
// Register offsets, field layouts and reset values of the pin-change block
`ifndef PCI_CONSTS_VH
`define PCI_CONSTS_VH
`define PCI_ADDR_W 4
`define PCI_OFF_PA_RISE 4'h0
`define PCI_OFF_PA_FALL 4'h1
`define PCI_OFF_PA_FLAG 4'h2
`define PCI_OFF_PC_RISE 4'h3
`define PCI_OFF_PC_FALL 4'h4
`define PCI_OFF_PC_FLAG 4'h5
`define PCI_OFF_CTRL 4'h6
`define PCI_OFF_IRQ_STAT 4'h7
`define PCI_OFF_IRQ_MASK 4'h8
`define PCI_PINS 6
`define PCI_EN_RST 6'h00
`define PCI_FLAG_RST 6'h00
`define PCI_CTRL_MEN_BIT 0
`define PCI_CTRL_SUM_BIT 1
`define PCI_CTRL_SLEEP_BIT 2
`define PCI_IRQ_PA_BIT 0
`define PCI_IRQ_PC_BIT 1
`define PCI_IRQ_W 2
`define PCI_IRQ_RST 2'h0
`endif

/* File: rtl/pci_pin_change.v */
// Pin-change interrupt block for two six-bit ports with Avalon-MM registers
//
// Behaviour
// - With master enable set, a flagged edge wakes the device from sleep.
// - Edges seen asleep are flagged before the core runs again.
// - Port A rising enable bits 5..0, one per pin.
// - Port A falling enable bits 5..0, one per pin.
// - Port A flag sets on an enabled rising or falling edge.
// - Port C rising enable bits 5..0, one per pin.
// - Port C falling enable bits 5..0, one per pin.
// - Port C flag sets on an enabled rising or falling edge.
// - A port A flag set also sets the summary flag.
// - A port C flag set also sets the summary flag.
// - Flags are sticky; software clears them by writing zero.
// - Bits 7 and 6 of every register read zero, ignore writes.
// - All enable and flag bits reset to zero.
// - Master enable clear: flags still set, pin_change_interrupt_o stays low; irq_o still follows irq_stat_q and irq_mask_q.
// - Both enables set detects edges of either polarity.
// - An edge during a flag write leaves that flag set.
// - Summary flag is the OR of all per-pin flags.
`timescale 1ns/10ps
`include "pci_consts.vh"
module pci_pin_change (
  input wire mclk_i,
  input wire reset_i,
  input wire [`PCI_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire [`PCI_PINS-1:0] port_a_pin_i,
  input wire [`PCI_PINS-1:0] port_c_pin_i,
  input wire sleep_i,
  output wire pin_change_summary_flag_o,
  output wire pin_change_interrupt_o,
  output wire wake_o,
  output wire irq_o
);

  // Three-stage synchronisers; stages two and three must agree
  reg [`PCI_PINS-1:0] pa_s1_q;
  reg [`PCI_PINS-1:0] pa_s2_q;
  reg [`PCI_PINS-1:0] pa_s3_q;
  reg [`PCI_PINS-1:0] pa_lvl_q;
  reg [`PCI_PINS-1:0] pc_s1_q;
  reg [`PCI_PINS-1:0] pc_s2_q;
  reg [`PCI_PINS-1:0] pc_s3_q;
  reg [`PCI_PINS-1:0] pc_lvl_q;
  reg [`PCI_PINS-1:0] pa_rise_q;
  reg [`PCI_PINS-1:0] pa_fall_q;
  reg [`PCI_PINS-1:0] pa_flag_q;
  reg [`PCI_PINS-1:0] pc_rise_q;
  reg [`PCI_PINS-1:0] pc_fall_q;
  reg [`PCI_PINS-1:0] pc_flag_q;
  reg men_q;
  reg [`PCI_IRQ_W-1:0] irq_stat_q;
  reg [`PCI_IRQ_W-1:0] irq_mask_q;
  reg ack_q;
  reg [`PCI_PINS-1:0] pa_flag_d;
  reg [`PCI_PINS-1:0] pc_flag_d;
  reg [`PCI_IRQ_W-1:0] irq_stat_d;
  reg [31:0] rdata_d;
  wire [`PCI_PINS-1:0] pa_hit;
  wire [`PCI_PINS-1:0] pc_hit;
  wire req;
  wire wr_en;
  wire summary;

  function hit_fn;
    input old_lvl;
    input new_lvl;
    input agree;
    input rise_en;
    input fall_en;
    begin
      hit_fn = agree & (old_lvl != new_lvl) &
        ((new_lvl & rise_en) | (~new_lvl & fall_en));
    end
  endfunction

  function wr_sel;
    input [`PCI_ADDR_W-1:0] addr;
    input [`PCI_ADDR_W-1:0] off;
    input we;
    input be0;
    begin
      wr_sel = we & be0 & (addr == off);
    end
  endfunction

  always @(posedge mclk_i) begin
    if (reset_i) begin
      pa_s1_q <= 6'h00;
      pa_s2_q <= 6'h00;
      pa_s3_q <= 6'h00;
      pc_s1_q <= 6'h00;
      pc_s2_q <= 6'h00;
      pc_s3_q <= 6'h00;
    end else begin
      pa_s1_q <= port_a_pin_i;
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
      pc_s1_q <= port_c_pin_i;
      pc_s2_q <= pc_s1_q;
      pc_s3_q <= pc_s2_q;
    end
  end

  // Accepted level tracks pins once settled; first compare after reset is harmless
  always @(posedge mclk_i) begin
    if (reset_i) begin
      pa_lvl_q <= 6'h00;
      pc_lvl_q <= 6'h00;
    end else begin
      pa_lvl_q <= (pa_s2_q == pa_s3_q) ? pa_s3_q : pa_lvl_q;
      pc_lvl_q <= (pc_s2_q == pc_s3_q) ? pc_s3_q : pc_lvl_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PCI_PINS; gi = gi + 1) begin : g_det
      assign pa_hit[gi] = hit_fn(pa_lvl_q[gi], pa_s3_q[gi], pa_s2_q[gi] == pa_s3_q[gi],
        pa_rise_q[gi], pa_fall_q[gi]);
      assign pc_hit[gi] = hit_fn(pc_lvl_q[gi], pc_s3_q[gi], pc_s2_q[gi] == pc_s3_q[gi],
        pc_rise_q[gi], pc_fall_q[gi]);
    end
  endgenerate

  // One-cycle answer: waitrequest low on the second cycle of a request
  assign req = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_waitrequest_o = req;
  assign wr_en = avs_write_i & ack_q;

  always @* begin
    pa_flag_d = pa_flag_q;
    pc_flag_d = pc_flag_q;
    if (wr_sel(avs_address_i, `PCI_OFF_PA_FLAG, wr_en, avs_byteenable_i[0])) begin
      pa_flag_d = avs_writedata_i[`PCI_PINS-1:0];
    end
    if (wr_sel(avs_address_i, `PCI_OFF_PC_FLAG, wr_en, avs_byteenable_i[0])) begin
      pc_flag_d = avs_writedata_i[`PCI_PINS-1:0];
    end
    pa_flag_d = pa_flag_d | pa_hit;
    pc_flag_d = pc_flag_d | pc_hit;
  end

  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr_sel(avs_address_i, `PCI_OFF_IRQ_STAT, wr_en, avs_byteenable_i[0])) begin
      irq_stat_d = irq_stat_q & ~avs_writedata_i[`PCI_IRQ_W-1:0];
    end
    irq_stat_d[`PCI_IRQ_PA_BIT] = irq_stat_d[`PCI_IRQ_PA_BIT] | (|pa_hit);
    irq_stat_d[`PCI_IRQ_PC_BIT] = irq_stat_d[`PCI_IRQ_PC_BIT] | (|pc_hit);
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      pa_rise_q <= `PCI_EN_RST;
      pa_fall_q <= `PCI_EN_RST;
      pc_rise_q <= `PCI_EN_RST;
      pc_fall_q <= `PCI_EN_RST;
      pa_flag_q <= `PCI_FLAG_RST;
      pc_flag_q <= `PCI_FLAG_RST;
      men_q <= 1'b0;
      irq_stat_q <= `PCI_IRQ_RST;
      irq_mask_q <= `PCI_IRQ_RST;
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
      pa_flag_q <= pa_flag_d;
      pc_flag_q <= pc_flag_d;
      irq_stat_q <= irq_stat_d;
      if (wr_sel(avs_address_i, `PCI_OFF_PA_RISE, wr_en, avs_byteenable_i[0])) begin
        pa_rise_q <= avs_writedata_i[`PCI_PINS-1:0];
      end
      if (wr_sel(avs_address_i, `PCI_OFF_PA_FALL, wr_en, avs_byteenable_i[0])) begin
        pa_fall_q <= avs_writedata_i[`PCI_PINS-1:0];
      end
      if (wr_sel(avs_address_i, `PCI_OFF_PC_RISE, wr_en, avs_byteenable_i[0])) begin
        pc_rise_q <= avs_writedata_i[`PCI_PINS-1:0];
      end
      if (wr_sel(avs_address_i, `PCI_OFF_PC_FALL, wr_en, avs_byteenable_i[0])) begin
        pc_fall_q <= avs_writedata_i[`PCI_PINS-1:0];
      end
      if (wr_sel(avs_address_i, `PCI_OFF_CTRL, wr_en, avs_byteenable_i[0])) begin
        men_q <= avs_writedata_i[`PCI_CTRL_MEN_BIT];
      end
      if (wr_sel(avs_address_i, `PCI_OFF_IRQ_MASK, wr_en, avs_byteenable_i[0])) begin
        irq_mask_q <= avs_writedata_i[`PCI_IRQ_W-1:0];
      end
    end
  end

  assign summary = (|pa_flag_q) | (|pc_flag_q);
  assign pin_change_summary_flag_o = summary;
  assign pin_change_interrupt_o = summary & men_q;
  // Flags update in the edge cycle, before the core can resume
  assign wake_o = sleep_i & summary & men_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);

  always @* begin
    rdata_d = 32'h00000000;
    case (avs_address_i)
      `PCI_OFF_PA_RISE: rdata_d[`PCI_PINS-1:0] = pa_rise_q;
      `PCI_OFF_PA_FALL: rdata_d[`PCI_PINS-1:0] = pa_fall_q;
      `PCI_OFF_PA_FLAG: rdata_d[`PCI_PINS-1:0] = pa_flag_q;
      `PCI_OFF_PC_RISE: rdata_d[`PCI_PINS-1:0] = pc_rise_q;
      `PCI_OFF_PC_FALL: rdata_d[`PCI_PINS-1:0] = pc_fall_q;
      `PCI_OFF_PC_FLAG: rdata_d[`PCI_PINS-1:0] = pc_flag_q;
      `PCI_OFF_CTRL: begin
        rdata_d[`PCI_CTRL_MEN_BIT] = men_q;
        rdata_d[`PCI_CTRL_SUM_BIT] = summary;
        rdata_d[`PCI_CTRL_SLEEP_BIT] = sleep_i;
      end
      `PCI_OFF_IRQ_STAT: rdata_d[`PCI_IRQ_W-1:0] = irq_stat_q;
      `PCI_OFF_IRQ_MASK: rdata_d[`PCI_IRQ_W-1:0] = irq_mask_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i & req) begin
      avs_readdata_o <= rdata_d;
    end
  end

endmodule

/* File: tb/pci_pin_change_props.sv */
// Port-level assertions for the pin-change block
`timescale 1ns/10ps
module pci_pin_change_props (
  input wire mclk_i,
  input wire reset_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire sleep_i,
  input wire pin_change_summary_flag_o,
  input wire pin_change_interrupt_o,
  input wire wake_o,
  input wire irq_o
);
  wire req = avs_read_i || avs_write_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("no wait cycle");
  a_wait_one: assert property ($rose(req) |=> !avs_waitrequest_o)
    else $error("wait too long");
  a_idle_nowait: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait while idle");
  a_read_upper: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:6] == 26'h0) else $error("upper bits set");
  a_int_needs_sum: assert property (pin_change_interrupt_o |-> pin_change_summary_flag_o)
    else $error("interrupt without flag");
  a_wake_gate: assert property (wake_o == (sleep_i && pin_change_interrupt_o))
    else $error("wake mismatch");
  a_flag_sticky: assert property ($fell(pin_change_summary_flag_o) |->
    $past(avs_write_i && !avs_waitrequest_o)) else $error("flag lost");
  a_reset_zero: assert property ($fell(reset_i) |->
    !pin_change_summary_flag_o && !irq_o && !wake_o) else $error("not cleared");
endmodule
bind pci_pin_change pci_pin_change_props u_props (.*);

/* File: tb/pci_pin_model.sv */
// External pin levels of ports A and C
`timescale 1ns/10ps
module pci_pin_model (
  input wire mclk_i,
  output logic [5:0] port_a_o,
  output logic [5:0] port_c_o
);
  initial begin
    port_a_o = 6'h00;
    port_c_o = 6'h00;
  end
  // Hold long enough for sync and flag
  task automatic drive(input logic [5:0] a, input logic [5:0] c);
    @(posedge mclk_i);
    port_a_o <= a;
    port_c_o <= c;
    repeat (7) @(posedge mclk_i);
  endtask
endmodule

/* File: tb/tb_pin_change_interrupt.sv */
// Self-checking bench for the pin-change block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_pin_change_interrupt;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rd = 1'b0, wr = 1'b0, sleep = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  wire [5:0] pa, pc;
  wire [31:0] rdata;
  wire wt, sum, pint, wake, irq;
  int num_errors = 0, checks_done = 0;
  pci_pin_model pins (.mclk_i(mclk_i), .port_a_o(pa), .port_c_o(pc));
  pci_pin_change uut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .port_a_pin_i(pa), .port_c_pin_i(pc), .sleep_i(sleep),
    .pin_change_summary_flag_o(sum), .pin_change_interrupt_o(pint), .wake_o(wake), .irq_o(irq));
  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    rdat = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic pins_chk(input logic [5:0] a, c, ea, ec);
    pins.drive(a, c);
    bus(1'b0, 4'h2, 32'h0);
    `CHK("flags a", {26'h0, ea}, rdat)
    bus(1'b0, 4'h5, 32'h0);
    `CHK("flags c", {26'h0, ec}, rdat)
  endtask
  task automatic t_regs;
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, i[3:0], 32'h0);
      `CHK("reset value", 32'h0, rdat)
    end
    for (int i = 0; i < 5; i++) begin
      if (i == 2) continue;
      bus(1'b1, i[3:0], 32'hFF);
      bus(1'b0, i[3:0], 32'h0);
      `CHK("enable bits", 32'h3F, rdat)
    end
    bus(1'b1, 4'hF, 32'hFF);
    bus(1'b0, 4'hF, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    bus(1'b1, 4'h0, 32'h05);
    bus(1'b1, 4'h1, 32'h0A);
    bus(1'b1, 4'h3, 32'h30);
    bus(1'b1, 4'h4, 32'h30);
  endtask
  task automatic t_edges;
    pins_chk(6'h3F, 6'h30, 6'h05, 6'h30);
    `CHK("summary", 1'b1, sum)
    `CHK("interrupt", 1'b0, pint)
    bus(1'b1, 4'h5, 32'h0);
    bus(1'b0, 4'h5, 32'h0);
    `CHK("cleared c", 32'h0, rdat)
    pins_chk(6'h00, 6'h00, 6'h0F, 6'h30);
    bus(1'b1, 4'h2, 32'h0);
    bus(1'b1, 4'h5, 32'h0);
    repeat (8) @(posedge mclk_i);
    `CHK("summary idle", 1'b0, sum)
  endtask
  task automatic t_wake;
    bus(1'b1, 4'h6, 32'h1);
    sleep <= 1'b1;
    pins.drive(6'h01, 6'h00);
    @(negedge mclk_i);
    `CHK("wake", 1'b1, wake)
    `CHK("interrupt", 1'b1, pint)
    bus(1'b0, 4'h2, 32'h0);
    `CHK("sleep flag", 32'h01, rdat)
    `CHK("irq masked", 1'b0, irq)
    bus(1'b0, 4'h6, 32'h0);
    `CHK("ctrl status", 32'h7, rdat)
    bus(1'b1, 4'h8, 32'h3);
    @(negedge mclk_i);
    `CHK("irq on", 1'b1, irq)
    bus(1'b1, 4'h7, 32'h3);
    @(negedge mclk_i);
    `CHK("irq cleared", 1'b0, irq)
    sleep <= 1'b0;
  endtask
  // Pin A2 rises so that its flag sets on the edge where a clearing write lands
  task automatic t_clear_race;
    fork
      pins.drive(6'h05, 6'h00);
      begin
        repeat (2) @(posedge mclk_i);
        bus(1'b1, 4'h2, 32'h0);
      end
    join
    bus(1'b0, 4'h2, 32'h0);
    `CHK("flag during clear", 32'h04, rdat)
  endtask
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_regs();
    t_edges();
    t_wake();
    t_clear_race();
    tally_and_finish();
  end
endmodule
